// File: logic/dst_defines.svh
// Constants of the switch-selected self-test block
`ifndef DST_DEFINES_SVH
`define DST_DEFINES_SVH

// ==========================================================
// Register offsets and reset values
`define DST_OFS_CTRL 8'h00
`define DST_OFS_STATUS 8'h04
`define DST_OFS_FAIL_ADDR 8'h08
`define DST_CTRL_RST 1'b1

// ==========================================================
// Status field positions
`define DST_ST_BUSY 0
`define DST_ST_PASS 1
`define DST_ST_FAIL 2
`define DST_ST_ERR 3
`define DST_ST_MODE_LO 4
`define DST_ST_CLEARED 6

// ==========================================================
// Switch codes {parity, even_odd, word_len}
`define DST_SW_SERIAL 3'h6
`define DST_SW_MEMORY 3'h1
`define DST_SW_CLOCK 3'h5
`define DST_SW_CLEAR 3'h7

// ==========================================================
// Timing, result characters and fill byte
`define DST_CLK_HZ 20000000
`define DST_BASE_BAUD 300
`define DST_NUM_BAUDS 7
`define DST_CHARS_PER_BAUD 32
`define DST_RESULT_BAUD_IDX 3'h2
`define DST_RTC_RUN_MS 1100
`define DST_RX_TMO_BITS 30
`define DST_CHAR_PASS 8'h50
`define DST_CHAR_FAIL 8'h46
`define DST_FACTORY_FILL 8'hFF

`endif

// File: logic/dst_pkg.sv
// Types shared by the self-test block
package dst_pkg;
	typedef enum logic [1:0] {
		DST_LBL_NONE,
		DST_LBL_SERIAL,
		DST_LBL_MEMORY,
		DST_LBL_CLOCK
	} dst_label_t;

	typedef enum logic [3:0] {
		S_BOOT,
		S_IDLE,
		S_SL_TX,
		S_SL_RX,
		S_MEM_RD,
		S_MEM_WAIT,
		S_MEM_CHK,
		S_MEM_NEXT,
		S_CLR,
		S_RTC_RD,
		S_RTC_WAIT,
		S_RTC_CHK,
		S_RTC_RUN,
		S_REPORT,
		S_REPORT_WAIT
	} dst_state_t;
endpackage

// File: logic/dst_self_test.sv
// Switch-selected self-test sequencer with Wishbone status registers
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`include "dst_defines.svh"

module dst_self_test #(
	parameter int AW = 11,
	parameter int RTC_W = 32,
	parameter int unsigned RUN_WAIT_CYC =
		`DST_CLK_HZ / 1000 * `DST_RTC_RUN_MS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sw_parity_i,
	input wire logic sw_even_odd_i,
	input wire logic sw_word_len_i,
	output logic cl_tx_o,
	input wire logic cl_rx_i,
	output logic rs_tx_o,
	input wire logic rs_rx_i,
	output logic [AW-1:0] nvm_addr_o,
	output logic [7:0] nvm_wdata_o,
	output logic nvm_we_o,
	input wire logic [7:0] nvm_rdata_i,
	output logic [RTC_W-1:0] rtc_wdata_o,
	output logic rtc_we_o,
	input wire logic [RTC_W-1:0] rtc_rdata_i,
	output dst_pkg::dst_label_t disp_label_o,
	output logic disp_pass_o,
	output logic disp_fail_o,
	output logic disp_sw_err_o
);
	import dst_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		dst_state_t st;
		logic [2:0] sw_prev;
		logic enable;
		logic ack;
		logic [31:0] rdat;
		dst_label_t label;
		logic pass;
		logic fail;
		logic err;
		logic cleared;
		logic [AW-1:0] fail_addr;
		logic [2:0] baud;
		logic [16:0] div;
		logic [4:0] chr;
		logic [7:0] sent;
		logic [9:0] tx_sh;
		logic [3:0] tx_bits;
		logic [16:0] tx_cnt;
		logic tx_busy;
		logic tx_line;
		logic [7:0] rx_sh;
		logic [3:0] rx_bits;
		logic [16:0] rx_cnt;
		logic rx_busy;
		logic rx_got;
		logic [31:0] tmo;
		logic [AW-1:0] addr;
		logic [7:0] orig;
		logic [7:0] wdata;
		logic we;
		logic [RTC_W-1:0] t0;
		logic rtc_we;
	} dst_regs_t;

	dst_regs_t q, d;
	logic [2:0] sw;
	logic rx_line;

	assign sw = {sw_parity_i, sw_even_odd_i, sw_word_len_i};
	assign rx_line = cl_rx_i & rs_rx_i;

	function automatic logic [16:0] baud_div(input logic [2:0] idx);
		baud_div = 17'((`DST_CLK_HZ) / ((`DST_BASE_BAUD) << idx));
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		d = q;
		d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
		d.rdat = 32'h0000_0000;
		d.we = 1'b0;
		d.rtc_we = 1'b0;
		d.rx_got = 1'b0;
		if (d.ack) begin
			unique case (wb_adr_i)
				`DST_OFS_CTRL: d.rdat[0] = q.enable;
				`DST_OFS_STATUS: begin
					d.rdat[`DST_ST_BUSY] = q.st != S_IDLE;
					d.rdat[`DST_ST_PASS] = q.pass;
					d.rdat[`DST_ST_FAIL] = q.fail;
					d.rdat[`DST_ST_ERR] = q.err;
					d.rdat[`DST_ST_MODE_LO +: 2] = q.label;
					d.rdat[`DST_ST_CLEARED] = q.cleared;
				end
				`DST_OFS_FAIL_ADDR: d.rdat[AW-1:0] = q.fail_addr;
				default: d.rdat = 32'h0000_0000;
			endcase
		end
		// Write lands at the edge that samples ack
		if (q.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
			&& wb_adr_i == `DST_OFS_CTRL) begin
			d.enable = wb_dat_i[0];
		end
		// Transmitter, 8N1, LSB first
		if (q.tx_busy) begin
			if (q.tx_cnt == 17'h0_0000) begin
				d.tx_cnt = q.div - 17'h0_0001;
				d.tx_sh = {1'b1, q.tx_sh[9:1]};
				d.tx_bits = q.tx_bits + 4'h1;
				if (q.tx_bits == 4'h9) begin
					d.tx_busy = 1'b0;
				end
			end else begin
				d.tx_cnt = q.tx_cnt - 17'h0_0001;
			end
		end
		// Receiver, sampled mid-bit
		if (!q.rx_busy) begin
			if (!rx_line) begin
				d.rx_busy = 1'b1;
				d.rx_cnt = q.div >> 1;
				d.rx_bits = 4'h0;
			end
		end else if (q.rx_cnt == 17'h0_0000) begin
			d.rx_cnt = q.div - 17'h0_0001;
			d.rx_bits = q.rx_bits + 4'h1;
			if (q.rx_bits == 4'h0) begin
				d.rx_busy = ~rx_line;
			end else if (q.rx_bits == 4'h9) begin
				d.rx_busy = 1'b0;
				d.rx_got = rx_line;
			end else begin
				d.rx_sh = {rx_line, q.rx_sh[7:1]};
			end
		end else begin
			d.rx_cnt = q.rx_cnt - 17'h0_0001;
		end
		// Sequencer
		unique case (q.st)
			S_BOOT: begin
				d.sw_prev = sw;
				if (sw == `DST_SW_CLEAR) begin
					d.st = S_CLR;
					d.addr = '0;
				end else begin
					d.st = S_IDLE;
					d.sw_prev = ~sw;
				end
			end
			S_IDLE: begin
				if (q.enable && sw != q.sw_prev) begin
					d.sw_prev = sw;
					d.pass = 1'b0;
					d.fail = 1'b0;
					d.err = 1'b0;
					d.label = DST_LBL_NONE;
					d.addr = '0;
					d.tmo = 32'h0000_0000;
					unique case (sw)
						`DST_SW_SERIAL: begin
							d.st = S_SL_TX;
							d.baud = 3'h0;
							d.chr = 5'h00;
							d.div = baud_div(3'h0);
						end
						`DST_SW_MEMORY: d.st = S_MEM_RD;
						`DST_SW_CLOCK: d.st = S_RTC_RD;
						`DST_SW_CLEAR: d.err = 1'b1;
						default: d.st = S_IDLE;
					endcase
				end
			end
			S_SL_TX: begin
				if (!q.tx_busy && !q.rx_busy) begin
					d.sent = {q.chr, q.baud};
					d.tx_sh = {1'b1, q.chr, q.baud, 1'b0};
					d.tx_bits = 4'h0;
					d.tx_cnt = q.div - 17'h0_0001;
					d.tx_busy = 1'b1;
					d.tmo = 32'h0000_0000;
					d.st = S_SL_RX;
				end
			end
			S_SL_RX: begin
				d.tmo = q.tmo + 32'h0000_0001;
				if (q.rx_got) begin
					if (q.rx_sh != q.sent) begin
						d.fail = 1'b1;
					end
					d.chr = q.chr + 5'h01;
					d.st = S_SL_TX;
					if (q.chr == 5'(`DST_CHARS_PER_BAUD - 1)) begin
						d.baud = q.baud + 3'h1;
						d.div = baud_div(q.baud + 3'h1);
						if (q.baud == 3'(`DST_NUM_BAUDS - 1)) begin
							d.st = S_REPORT;
						end
					end
				end else if (q.tmo > 32'(q.div) * `DST_RX_TMO_BITS) begin
					d.fail = 1'b1;
					d.st = S_REPORT;
				end
				if (d.st == S_REPORT) begin
					d.label = DST_LBL_SERIAL;
				end
			end
			S_MEM_RD: begin
				d.orig = nvm_rdata_i;
				d.wdata = ~nvm_rdata_i;
				d.we = 1'b1;
				d.st = S_MEM_WAIT;
			end
			S_MEM_WAIT: d.st = S_MEM_CHK;
			S_MEM_CHK: begin
				if (nvm_rdata_i != q.wdata && !q.fail) begin
					d.fail = 1'b1;
					d.fail_addr = q.addr;
				end
				d.wdata = q.orig;
				d.we = 1'b1;
				d.st = S_MEM_NEXT;
			end
			S_MEM_NEXT: begin
				d.addr = q.addr + AW'(1);
				d.st = S_MEM_RD;
				if (&q.addr) begin
					d.label = DST_LBL_MEMORY;
					d.st = S_REPORT;
				end
			end
			S_CLR: begin
				d.wdata = `DST_FACTORY_FILL;
				d.we = 1'b1;
				d.addr = q.addr + AW'(q.we);
				if (q.we && &q.addr) begin
					d.we = 1'b0;
					d.cleared = 1'b1;
					d.st = S_IDLE;
				end
			end
			S_RTC_RD: begin
				d.t0 = rtc_rdata_i;
				d.rtc_we = 1'b1;
				d.st = S_RTC_WAIT;
			end
			S_RTC_WAIT: d.st = S_RTC_CHK;
			S_RTC_CHK: begin
				if (rtc_rdata_i - q.t0 > RTC_W'(1)) begin
					d.fail = 1'b1;
				end
				d.t0 = rtc_rdata_i;
				d.tmo = 32'h0000_0000;
				d.st = S_RTC_RUN;
			end
			S_RTC_RUN: begin
				d.tmo = q.tmo + 32'h0000_0001;
				if (rtc_rdata_i != q.t0 || q.tmo >= RUN_WAIT_CYC) begin
					if (rtc_rdata_i == q.t0) begin
						d.fail = 1'b1;
					end
					d.label = DST_LBL_CLOCK;
					d.st = S_REPORT;
				end
			end
			S_REPORT: begin
				if (!q.tx_busy) begin
					d.div = baud_div(`DST_RESULT_BAUD_IDX);
					d.tx_sh = {1'b1, q.fail ? `DST_CHAR_FAIL
						: `DST_CHAR_PASS, 1'b0};
					d.tx_bits = 4'h0;
					d.tx_cnt = baud_div(`DST_RESULT_BAUD_IDX) - 17'h0_0001;
					d.tx_busy = 1'b1;
					d.pass = ~q.fail;
					d.st = S_REPORT_WAIT;
				end
			end
			S_REPORT_WAIT: begin
				if (!q.tx_busy) begin
					d.st = S_IDLE;
				end
			end
			default: d.st = S_IDLE;
		endcase
		d.tx_line = d.tx_busy ? d.tx_sh[0] : 1'b1;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.st <= S_BOOT;
			q.enable <= `DST_CTRL_RST;
			q.tx_line <= 1'b1;
			q.div <= 17'h0_0001;
		end else begin
			q <= d;
		end
	end

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdat;
	assign cl_tx_o = q.tx_line;
	assign rs_tx_o = q.tx_line;
	assign nvm_addr_o = q.addr;
	assign nvm_wdata_o = q.wdata;
	assign nvm_we_o = q.we;
	assign rtc_wdata_o = q.t0;
	assign rtc_we_o = q.rtc_we;
	assign disp_label_o = q.label;
	assign disp_pass_o = q.pass;
	assign disp_fail_o = q.fail;
	assign disp_sw_err_o = q.err;

	// ==========================================================
	// Checks
	sequence mem_chk_seq;
		q.st == S_MEM_CHK;
	endsequence

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	a_clear_boot_only: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(q.st != S_BOOT && q.st != S_CLR) |=> (q.st != S_CLR))
		else $error("clear entered outside power-up");
	a_late_clear_err: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(q.st == S_IDLE && q.enable && sw == `DST_SW_CLEAR
		&& q.sw_prev != sw) |=> disp_sw_err_o && !nvm_we_o)
		else $error("late clear code not flagged");
	a_mem_restore: assert property (@(posedge clk_i)
		disable iff (rst_i)
		mem_chk_seq |=> nvm_we_o && nvm_wdata_o == q.orig)
		else $error("original byte not restored");
	a_mem_invert: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(q.st == S_MEM_RD) |=> nvm_we_o
		&& nvm_wdata_o == ~$past(nvm_rdata_i))
		else $error("test pattern not written");
	a_rtc_same: assert property (@(posedge clk_i)
		disable iff (rst_i)
		rtc_we_o |-> rtc_wdata_o == $past(rtc_rdata_i))
		else $error("clock written with other time");
	a_report_char: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(q.st == S_REPORT && !q.tx_busy) |=> q.tx_busy
		&& q.tx_sh[8:1] == (disp_fail_o ? `DST_CHAR_FAIL
		: `DST_CHAR_PASS) && q.div == baud_div(`DST_RESULT_BAUD_IDX))
		else $error("wrong result character or rate");
	a_result_excl: assert property (@(posedge clk_i)
		disable iff (rst_i)
		!(disp_pass_o && disp_fail_o))
		else $error("pass and fail both shown");
	a_serial_start: assert property (@(posedge clk_i)
		disable iff (rst_i)
		(q.st == S_IDLE && q.enable && sw == `DST_SW_SERIAL
		&& q.sw_prev != sw) |=> q.st == S_SL_TX ##1 q.st == S_SL_RX)
		else $error("serial test not launched");
endmodule

// File: verif/dst_loopback.sv
// Loop-back plug on the serial ports of the unit
`timescale 1ns/1ps
// ==========
// Plug
module dst_loopback (
	input wire logic cl_tx_i,
	input wire logic rs_tx_i,
	input wire logic use_rs_i,
	output logic cl_rx_o,
	output logic rs_rx_o
);
	// Unplugged port rests at mark
	assign cl_rx_o = use_rs_i ? 1'b1 : cl_tx_i;
	assign rs_rx_o = use_rs_i ? rs_tx_i : 1'b1;
endmodule

// File: verif/dst_self_test_bench.sv
// Self-checking bench of the self-test sequencer
`timescale 1ns/1ps
`include "dst_defines.svh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
	errors++; $display("ERROR %s expected %h seen %h", n, e, a); end end
module dst_self_test_bench;
	import dst_pkg::*;
	// ==========
	// Signals and models
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
	logic [7:0] adr = 0, nwd, nrd;
	logic [3:0] sel = 0, na;
	logic [31:0] wdat = 0, rdat, rwd, rtc = 0, ref_t = 0, q;
	logic [2:0] sw = 0;
	logic cl_tx, cl_rx, rs_tx, rs_rx, nwe, rwe, ps, fl, er;
	logic use_rs = 0, tick = 1, stuck = 0;
	logic [7:0] mem [16], keep [16];
	dst_label_t lbl;
	int errors = 0, checks_done = 0, cyc_n = 0, nwe_n = 0;
	int seed = 54, t, tk = 0;
	always #25 clk = ~clk;
	dst_self_test #(.AW(4), .RUN_WAIT_CYC(200)) DUT (
		.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .sw_parity_i(sw[2]),
		.sw_even_odd_i(sw[1]), .sw_word_len_i(sw[0]), .cl_tx_o(cl_tx),
		.cl_rx_i(cl_rx), .rs_tx_o(rs_tx), .rs_rx_i(rs_rx),
		.nvm_addr_o(na), .nvm_wdata_o(nwd), .nvm_we_o(nwe),
		.nvm_rdata_i(nrd), .rtc_wdata_o(rwd), .rtc_we_o(rwe),
		.rtc_rdata_i(rtc), .disp_label_o(lbl), .disp_pass_o(ps),
		.disp_fail_o(fl), .disp_sw_err_o(er));
	dst_loopback LB (.cl_tx_i(cl_tx), .rs_tx_i(rs_tx),
		.use_rs_i(use_rs), .cl_rx_o(cl_rx), .rs_rx_o(rs_rx));
	assign nrd = mem[na];
	// Memory with an optional dead cell, clock ticking every 20 cycles
	always @(posedge clk) begin
		cyc_n++;
		tk = (tk + 1) % 20;
		nwe_n += int'(nwe);
		if (nwe && !(stuck && na == 4'h5))
			mem[na] <= nwd;
		if (rwe)
			rtc <= rwd;
		else if (tick && tk == 0 && !rst)
			rtc <= rtc + 1;
		if (tick && tk == 0 && !rst)
			ref_t <= ref_t + 1;
		if (cyc_n == 60000) begin
			errors++;
			report_and_stop();
		end
	end
	// ==========
	// Tasks
	function automatic logic frame_bit(input logic [7:0] c, input int k);
		return (k == 0) ? 1'b0 : c[k-1];
	endfunction
	task automatic report_and_stop();
		if (errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1)
			errors++;
		q = rdat;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask
	task automatic boot(input logic [2:0] c);
		logic [31:0] v;
		rst <= 1;
		sw <= c;
		@(posedge clk);
		for (int i = 0; i < 16; i++) begin
			v = $random(seed);
			mem[i] <= v[7:0];
			keep[i] = v[7:0];
		end
		v = $random(seed);
		rtc <= v;
		ref_t <= v;
		repeat (19) @(posedge clk);
		rst <= 0;
	endtask
	task automatic wait_for(input bit tx_low);
		t = 0;
		while (t < 3000 && (tx_low ? cl_tx !== 1'b0 :
			(ps !== 1'b1 && fl !== 1'b1))) begin
			@(posedge clk);
			t++;
		end
		if (t >= 3000)
			errors++;
	endtask
	task automatic mem_same();
		for (int i = 0; i < 16; i++)
			`CHK("nvm", keep[i], mem[i])
	endtask
	// ==========
	// Scenarios
	initial begin
		boot(3'h0);
		wb(0, 8'h00, 0);
		`CHK("ctrl", 32'h0000_0001, q)
		wb(0, 8'h0C, 0);
		`CHK("unmapped", 32'h0000_0000, q)
		wb(1, 8'h00, 0);
		sw <= `DST_SW_MEMORY;
		nwe_n = 0;
		repeat (30) @(posedge clk);
		`CHK("held", 0, nwe_n)
		wb(1, 8'h00, 1);
		wait_for(0);
		`CHK("mem pass", 1'b1, ps)
		`CHK("mem label", DST_LBL_MEMORY, lbl)
		mem_same();
		wait_for(1);
		nwe_n = 0;
		repeat (8333) @(posedge clk);
		`CHK("start", frame_bit(`DST_CHAR_PASS, 0), cl_tx)
		repeat (33332) @(posedge clk);
		`CHK("bit1", frame_bit(`DST_CHAR_PASS, 2), cl_tx)
		`CHK("tx pair", cl_tx, rs_tx)
		`CHK("rerun", 0, nwe_n)
		stuck <= 1;
		boot(`DST_SW_MEMORY);
		wait_for(0);
		`CHK("mem fail", 1'b1, fl)
		wb(0, 8'h08, 0);
		`CHK("fail addr", 32'h0000_0005, q)
		stuck <= 0;
		boot(`DST_SW_CLOCK);
		wait_for(0);
		`CHK("rtc pass", 1'b1, ps)
		`CHK("rtc label", DST_LBL_CLOCK, lbl)
		`CHK("rtc kept", 1'b1, (ref_t - rtc) <= 32'h0000_0001)
		tick <= 0;
		boot(`DST_SW_CLOCK);
		wait_for(0);
		`CHK("rtc stop", 1'b1, fl)
		tick <= 1;
		boot(`DST_SW_CLEAR);
		repeat (40) @(posedge clk);
		for (int i = 0; i < 16; i++)
			`CHK("cleared", `DST_FACTORY_FILL, mem[i])
		wb(0, 8'h04, 0);
		`CHK("boot clr", 1'b1, q[6])
		boot(3'h0);
		repeat (5) @(posedge clk);
		sw <= `DST_SW_CLEAR;
		repeat (10) @(posedge clk);
		`CHK("sw err", 1'b1, er)
		mem_same();
		for (int u = 0; u < 2; u++) begin
			use_rs <= u[0];
			boot(`DST_SW_SERIAL);
			wait_for(1);
			`CHK("echo", 1'b0, u ? rs_rx : cl_rx)
			wb(0, 8'h04, 0);
			`CHK("sl busy", 1'b1, q[0])
		end
		report_and_stop();
	end
endmodule
